// ### rtl/fieldconv_pkg.sv
// constants shared by the progressive-to-field converter and its peer
package fieldconv_pkg;
  localparam int PIX_W = 24;
  localparam int DIM_W = 16;
  localparam logic FIELD_ODD = 1'b0;
  localparam logic FIELD_EVEN = 1'b1;
  localparam logic [DIM_W-1:0] DIM_ONE = 16'h0001;
  localparam logic [DIM_W-1:0] DIM_ZERO = 16'h0000;
  localparam logic [PIX_W-1:0] PIX_ZERO = 24'h000000;
endpackage

// ### rtl/video_link_if.sv
// valid-ready video link between the converter and its source/sink peer
`timescale 1ns/100ps
interface video_link_if;
  import fieldconv_pkg::*;
  logic [PIX_W-1:0] in_pix;
  logic in_vsync;
  logic in_hsync;
  logic in_valid;
  logic in_ready;
  logic [PIX_W-1:0] out_pix;
  logic out_field;
  logic out_vsync;
  logic out_hsync;
  logic out_valid;
  logic out_ready;
  modport conv (
    input in_pix, in_vsync, in_hsync, in_valid, output in_ready,
    output out_pix, out_field, out_vsync, out_hsync, out_valid, input out_ready
  );
  modport peer (
    output in_pix, in_vsync, in_hsync, in_valid, input in_ready,
    input out_pix, out_field, out_vsync, out_hsync, out_valid, output out_ready
  );
endinterface

// ### rtl/field_converter.sv
// converter end: keeps every other line of each progressive frame as one field
`timescale 1ns/100ps
module field_converter (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // frame geometry
  input wire logic [fieldconv_pkg::DIM_W-1:0] pixels_per_line,
  input wire logic [fieldconv_pkg::DIM_W-1:0] lines_per_frame,
  // video link
  video_link_if.conv link,
  // status
  output logic next_field
);
  import fieldconv_pkg::*;

  // counters step and compare in one place so widths stay uniform
  function automatic logic [DIM_W-1:0] dim_inc(input logic [DIM_W-1:0] v);
    return v + DIM_ONE;
  endfunction

  function automatic logic [DIM_W-1:0] dim_dec(input logic [DIM_W-1:0] v);
    return v - DIM_ONE;
  endfunction

  function automatic logic dim_is_zero(input logic [DIM_W-1:0] v);
    return v == DIM_ZERO;
  endfunction

  function automatic logic dim_eq(input logic [DIM_W-1:0] a, input logic [DIM_W-1:0] b);
    return a == b;
  endfunction

  // position of the word last taken
  logic [DIM_W-1:0] col_r;
  logic [DIM_W-1:0] row_r;
  logic started_r;
  logic parity_r;
  // output stage
  logic [PIX_W-1:0] pix_r;
  logic valid_r;
  logic field_r;
  logic vsync_r;
  logic hsync_r;

  // next values
  logic [DIM_W-1:0] col_nxt;
  logic [DIM_W-1:0] row_nxt;
  logic started_nxt;
  logic parity_nxt;
  logic [PIX_W-1:0] pix_nxt;
  logic valid_nxt;
  logic field_nxt;
  logic vsync_nxt;
  logic hsync_nxt;

  // decode of the incoming word
  logic [DIM_W-1:0] last_col;
  logic [DIM_W-1:0] last_row;
  logic stall_out;
  logic take_in;
  logic take_out;
  logic frame_start;
  logic line_wrap;
  logic line_start;
  logic [DIM_W-1:0] cur_col;
  logic [DIM_W-1:0] cur_row;
  logic col_first;
  logic col_last;
  logic row_last;
  logic frame_end;
  logic keep;
  logic first_kept_row;
  logic load;

  // geometry taken straight from the inputs, no shadowing
  assign last_col = dim_dec(pixels_per_line);
  assign last_row = dim_dec(lines_per_frame);

  // stage frees whenever its word leaves, so one pixel per clock
  assign stall_out = valid_r && !link.out_ready;
  assign take_in = link.in_valid && link.in_ready;
  assign take_out = link.out_valid && link.out_ready;
  assign link.in_ready = !stall_out;

  // a frame starts on the input flag or on the first pixel after reset or frame end
  assign frame_start = link.in_vsync || !started_r;
  // a line wraps on its own when the source leaves out line starts
  assign line_wrap = dim_eq(col_r, last_col);
  assign line_start = frame_start || link.in_hsync || line_wrap;
  assign cur_col = line_start ? DIM_ZERO : dim_inc(col_r);
  assign cur_row = frame_start ? DIM_ZERO :
    (line_start ? dim_inc(row_r) : row_r);
  assign col_first = dim_is_zero(cur_col);
  assign col_last = dim_eq(cur_col, last_col);
  assign row_last = dim_eq(cur_row, last_row);
  assign frame_end = row_last && col_last;

  // row index 0 is line one, so the odd field keeps even indices; half of the lines survive
  assign keep = (cur_row[0] == parity_r);
  assign first_kept_row = dim_is_zero({1'b0, cur_row[DIM_W-1:1]});
  assign load = take_in && keep;

  // position tracking and parity toggle, one field per frame
  assign col_nxt = take_in ? cur_col : col_r;
  assign row_nxt = take_in ? cur_row : row_r;
  assign started_nxt = take_in ? !frame_end : started_r;
  assign parity_nxt = (take_in && frame_end) ? !parity_r : parity_r;

  // single output register; holds under stall, empties by itself
  assign valid_nxt = load || (valid_r && !take_out);

  // dropped lines never touch the data register, so a stalled word is safe
  assign pix_nxt = load ? link.in_pix : pix_r;
  assign field_nxt = load ? parity_r : field_r;
  assign vsync_nxt = load ? (first_kept_row && col_first) : vsync_r;
  assign hsync_nxt = load ? col_first : hsync_r;

  // status and link outputs straight from the registers
  assign link.out_pix = pix_r;
  assign link.out_valid = valid_r;
  assign link.out_field = field_r;
  assign link.out_vsync = vsync_r;
  assign link.out_hsync = hsync_r;
  assign next_field = parity_r;

  // column of the last word taken
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      col_r <= DIM_ZERO;
    end else begin
      col_r <= col_nxt;
    end
  end

  // row of the last word taken
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      row_r <= DIM_ZERO;
    end else begin
      row_r <= row_nxt;
    end
  end

  // cleared at frame end so the next word opens a frame
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      started_r <= 1'b0;
    end else begin
      started_r <= started_nxt;
    end
  end

  // reset leaves the next field odd
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      parity_r <= FIELD_ODD;
    end else begin
      parity_r <= parity_nxt;
    end
  end

  // output valid, dropped by reset so the stage starts empty
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
    end
  end

  // pixel word, passed as an opaque value
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pix_r <= PIX_ZERO;
    end else begin
      pix_r <= pix_nxt;
    end
  end

  // field flag captured with each word
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      field_r <= FIELD_ODD;
    end else begin
      field_r <= field_nxt;
    end
  end

  // field start flag
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vsync_r <= 1'b0;
    end else begin
      vsync_r <= vsync_nxt;
    end
  end

  // line start flag
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hsync_r <= 1'b0;
    end else begin
      hsync_r <= hsync_nxt;
    end
  end
endmodule

// ### rtl/video_peer.sv
// peer end: frames user pixels with sync flags and collects the output field
`timescale 1ns/100ps
module video_peer (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // frame geometry
  input wire logic [fieldconv_pkg::DIM_W-1:0] pixels_per_line,
  input wire logic [fieldconv_pkg::DIM_W-1:0] lines_per_frame,
  // user source
  input wire logic [fieldconv_pkg::PIX_W-1:0] src_pix,
  input wire logic src_valid,
  output logic src_ready,
  // user sink
  input wire logic snk_ready,
  input wire logic snk_tie_ready,
  output logic [fieldconv_pkg::PIX_W-1:0] snk_pix,
  output logic snk_field,
  output logic snk_vsync,
  output logic snk_hsync,
  output logic snk_valid,
  // video link
  video_link_if.peer link
);
  import fieldconv_pkg::*;

  logic [DIM_W-1:0] col_r;
  logic [DIM_W-1:0] row_r;
  logic [PIX_W-1:0] pix_r;
  logic valid_r;
  logic vsync_r;
  logic hsync_r;
  logic [PIX_W-1:0] snk_pix_r;
  logic snk_field_r;
  logic snk_vsync_r;
  logic snk_hsync_r;
  logic snk_valid_r;

  wire link_take = link.in_valid && link.in_ready;
  assign src_ready = !valid_r || link.in_ready;
  wire src_take = src_valid && src_ready;
  wire col_last = (col_r == pixels_per_line - DIM_ONE);
  wire row_last = (row_r == lines_per_frame - DIM_ONE);

  // tying ready high is allowed only when the user sink never stalls
  assign link.out_ready = snk_ready || snk_tie_ready;
  wire out_take = link.out_valid && link.out_ready;

  assign link.in_pix = pix_r;
  assign link.in_valid = valid_r;
  assign link.in_vsync = vsync_r;
  assign link.in_hsync = hsync_r;
  assign snk_pix = snk_pix_r;
  assign snk_field = snk_field_r;
  assign snk_vsync = snk_vsync_r;
  assign snk_hsync = snk_hsync_r;
  assign snk_valid = snk_valid_r;

  // raster position of the next user pixel
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      col_r <= DIM_ZERO;
      row_r <= DIM_ZERO;
    end else if (src_take) begin
      col_r <= col_last ? DIM_ZERO : col_r + DIM_ONE;
      if (col_last) begin
        row_r <= row_last ? DIM_ZERO : row_r + DIM_ONE;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      valid_r <= 1'b0;
      pix_r <= PIX_ZERO;
      vsync_r <= 1'b0;
      hsync_r <= 1'b0;
    end else if (src_take) begin
      valid_r <= 1'b1;
      pix_r <= src_pix;
      vsync_r <= (col_r == DIM_ZERO) && (row_r == DIM_ZERO);
      hsync_r <= (col_r == DIM_ZERO);
    end else if (link_take) begin
      valid_r <= 1'b0;
    end
  end

  // captured output word, valid for one cycle per transfer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      snk_valid_r <= 1'b0;
      snk_pix_r <= PIX_ZERO;
      snk_field_r <= FIELD_ODD;
      snk_vsync_r <= 1'b0;
      snk_hsync_r <= 1'b0;
    end else begin
      snk_valid_r <= out_take;
      if (out_take) begin
        snk_pix_r <= link.out_pix;
        snk_field_r <= link.out_field;
        snk_vsync_r <= link.out_vsync;
        snk_hsync_r <= link.out_hsync;
      end
    end
  end
endmodule

// ### bench/fieldconv_checker.sv
// assertions on the video link between converter and peer
`timescale 1ns/100ps
module fieldconv_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link
  input wire logic [23:0] in_pix,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [23:0] out_pix,
  input wire logic out_field,
  input wire logic out_vsync,
  input wire logic out_hsync,
  input wire logic out_valid,
  input wire logic out_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic fld_r;
  logic seen_r;
  // parity of the last word taken, kept to spot a flip inside a field
  always_ff @(posedge mclk) begin
    seen_r <= rst_n && (seen_r || (out_valid && out_ready));
    if (out_valid && out_ready) fld_r <= out_field;
  end
  reset_idle_a: assert property ($rose(rst_n) |-> !out_valid && !out_field) else $error("busy after reset");
  ready_back_a: assert property (!in_ready |-> out_valid && !out_ready) else $error("input refused");
  out_rate_a: assert property (out_valid && out_ready |-> in_ready) else $error("rate lost");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_pix)) else $error("word lost");
  flag_hold_a: assert property (out_valid && !out_ready |=> $stable({out_field, out_vsync, out_hsync}))
    else $error("flags moved");
  new_word_a: assert property ($rose(out_valid) |-> $past(in_valid && in_ready) && out_pix == $past(in_pix))
    else $error("word altered");
  self_drain_a: assert property (out_valid && out_ready && !in_valid |=> !out_valid) else $error("no drain");
  field_start_a: assert property (out_valid && out_vsync |-> out_hsync) else $error("start unflagged");
  field_const_a: assert property (out_valid && !out_vsync && seen_r |-> out_field == fld_r)
    else $error("parity flip");
endmodule

// ### bench/progressive_to_field_converter_tb.sv
// bench: 3x4 frames through the peer, fields checked at the sink
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; $display("MISMATCH %0t bad", $time); end end
module progressive_to_field_converter_tb;
  import fieldconv_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [DIM_W-1:0] ppl = 16'h0003;
  logic [DIM_W-1:0] lpf = 16'h0004;
  logic [PIX_W-1:0] src_pix = PIX_ZERO;
  logic src_valid = 1'b0;
  logic snk_ready = 1'b1;
  logic snk_tie_ready = 1'b0;
  logic stall = 1'b0;
  logic src_ready, snk_field, snk_vsync, snk_hsync, snk_valid, next_field;
  logic [PIX_W-1:0] snk_pix;
  logic [PIX_W+2:0] got[$];
  int failures = 0;
  int n_compared = 0;
  video_link_if link();
  field_converter i_field_converter (.mclk(mclk), .rst_n(rst_n), .pixels_per_line(ppl), .lines_per_frame(lpf),
    .link(link), .next_field(next_field));
  video_peer i_video_peer (.mclk(mclk), .rst_n(rst_n), .pixels_per_line(ppl), .lines_per_frame(lpf),
    .src_pix(src_pix), .src_valid(src_valid), .src_ready(src_ready), .snk_ready(snk_ready),
    .snk_tie_ready(snk_tie_ready), .snk_pix(snk_pix), .snk_field(snk_field), .snk_vsync(snk_vsync),
    .snk_hsync(snk_hsync), .snk_valid(snk_valid), .link(link));
  fieldconv_checker i_fieldconv_checker (.mclk(mclk), .rst_n(rst_n), .in_pix(link.in_pix),
    .in_valid(link.in_valid), .in_ready(link.in_ready), .out_pix(link.out_pix), .out_field(link.out_field),
    .out_vsync(link.out_vsync), .out_hsync(link.out_hsync), .out_valid(link.out_valid), .out_ready(link.out_ready));
  initial forever #25 mclk = ~mclk;
  // stalling sink drops ready every other cycle
  always @(negedge mclk) snk_ready <= stall ? ~snk_ready : 1'b1;
  // sampled mid-cycle, away from the edge that launches the sink pulse
  always @(negedge mclk) if (snk_valid) got.push_back({snk_field, snk_vsync, snk_hsync, snk_pix});
  task automatic print_verdict;
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic send_frame(input logic [PIX_W-1:0] base);
    for (int i = 0; i < 12; i++) begin
      @(negedge mclk);
      src_pix = base + PIX_W'(i);
      src_valid = 1'b1;
      #1;
      for (int t = 0; !src_ready; t++) begin
        if (t > 50) begin
          failures++;
          print_verdict();
        end
        @(negedge mclk);
        #1;
      end
      @(posedge mclk);
    end
    @(negedge mclk);
    src_valid = 1'b0;
  endtask
  task automatic check_field(input logic [PIX_W-1:0] base, input logic par);
    logic [PIX_W+2:0] w;
    for (int t = 0; got.size() < 6; t++) begin
      if (t > 100) begin
        failures++;
        print_verdict();
      end
      @(negedge mclk);
    end
    repeat (4) @(negedge mclk);
    `CHK(got.size(), 6)
    for (int r = par; r < 4; r += 2) begin
      for (int c = 0; c < 3; c++) begin
        w = got.pop_front();
        `CHK(w[PIX_W-1:0], base + PIX_W'(r * 3 + c))
        `CHK(w[PIX_W+2], par)
        `CHK(w[PIX_W+1], r == par && c == 0)
        `CHK(w[PIX_W], c == 0)
      end
    end
    got.delete();
  endtask
  task automatic t_two_frames;
    `CHK(next_field, FIELD_ODD)
    send_frame(24'h000100);
    check_field(24'h000100, FIELD_ODD);
    send_frame(24'h000200);
    check_field(24'h000200, FIELD_EVEN);
  endtask
  task automatic t_stalled_frame;
    stall = 1'b1;
    send_frame(24'hA00000);
    check_field(24'hA00000, FIELD_ODD);
  endtask
  task automatic t_tied_ready;
    snk_tie_ready = 1'b1;
    send_frame(24'hFFFFF0);
    check_field(24'hFFFFF0, FIELD_EVEN);
    `CHK(next_field, FIELD_ODD)
  endtask
  initial begin
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    t_two_frames();
    t_stalled_frame();
    t_tied_ready();
    print_verdict();
  end
endmodule
